// ==== src/acs_chan_step.sv ====
// Purpose: next input channel of a multi-channel sequence
// Assumes: channels are 4-bit codes
// Notes: pure combinational step
`timescale 1ns/1ps
module acs_chan_step
    import acs_pkg::*;
(
    // current channel and wrap point
    input wire acs_chan_t curChan,
    input wire acs_chan_t wrapChan,
    // following channel
    output acs_chan_t nextChan
);
    // beyond the wrap point the 4-bit add rolls 15 to 0 by itself
    assign nextChan = (curChan == wrapChan) ? 4'h0 : curChan + 4'h1; // RQ9 RQ10
endmodule

// ==== src/acs_map.svh ====
// Purpose: register offsets, field positions and reset values
// Assumes: 8-bit register port, offsets are plain register indices
// Notes: included by the sequence controller, its assertions and the testbench
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

// register offsets
`define ACS_OFS_WRAP 4'h0
`define ACS_OFS_SEQCFG 4'h3
`define ACS_OFS_START 4'h5
`define ACS_OFS_STATUS 4'h6

// start control fields
`define ACS_START_SPECIAL 6
`define ACS_START_SCAN 5
`define ACS_START_ACROSS_CHANNELS_MODE 4
`define ACS_START_CODE_HI 3
`define ACS_START_CODE_LO 0
`define ACS_START_WMASK 8'h7F

// sequence configuration fields
`define ACS_SEQCFG_TRIGEN 7
`define ACS_SEQCFG_LEN_HI 3
`define ACS_SEQCFG_LEN_LO 0
`define ACS_SEQCFG_WMASK 8'h8F

// status fields
`define ACS_STAT_DONE 7
`define ACS_STAT_OVERRUN 5
`define ACS_STAT_RSVD 4

// reset values
`define ACS_RST_START 8'h00
`define ACS_RST_WRAP 4'h0
`define ACS_RST_LEN 4'h0

// special channel codes and full length
`define ACS_CODE_REFHI 4'h4
`define ACS_CODE_REFLO 4'h5
`define ACS_CODE_REFMID 4'h6
`define ACS_LEN_FULL 5'h10

`endif

// ==== src/acs_pkg.sv ====
// Purpose: types shared by the sequence controller files
// Assumes: nothing
// Notes: numbers live in acs_map.svh
package acs_pkg;
    typedef logic [3:0] acs_chan_t;
    typedef logic [7:0] acs_byte_t;
    typedef enum logic [1:0] {
        ACS_IDLE,
        ACS_ISSUE,
        ACS_WAIT
    } acs_state_e;
endpackage

// ==== src/acs_seq_ctrl.sv ====
// Purpose: start control and channel sequencing of the converter
// Assumes: 200 MHz clk, sample stage reports each finished conversion
// Notes: non-queued result counting, counter cleared at each start
`timescale 1ns/1ps
`include "acs_map.svh"

// Summary of operation
// RQ1 - A write to the start control register aborts any running sequence and starts a new one with the new fields.
// RQ2 - With external triggering on, one start write arms the block and then each trigger starts one sequence.
// RQ3 - A conversion starts with the sample phase of the first selected channel.
// RQ4 - Bit 6 set makes the channel code pick internal special channels, clear disables them.
// RQ5 - Bit 5 clear runs one sequence and stops, set repeats sequences without end.
// RQ6 - While external triggering is on, bit 5 is ignored and each trigger runs exactly one sequence.
// RQ7 - Bit 4 clear samples only the coded channel for every conversion of the sequence.
// RQ8 - Bit 4 set starts at the coded channel and steps up one per conversion for the configured count.
// RQ9 - In multi-channel mode the channel after the wrap channel is channel 0.
// RQ10 - A sequence starting above the wrap channel climbs to channel 15 before its first wrap to 0.
// RQ11 - With bit 6 clear, code bits 3 to 0 select external inputs 0 to 15 by binary value.
// RQ12 - With bit 6 set, codes 4, 5 and 6 select high, low and mid reference, other codes are reserved.
// RQ13 - The start control register sits at offset 5 and may be read and written at any time.
// RQ14 - The 4-bit sequence length gives the conversion count, with zero meaning 16.
// RQ15 - A start write clears the sequence done flag and resets the conversion counter.
// RQ16 - Bit 7 of the start control register reads zero and ignores writes.
module acs_seq_ctrl
    import acs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    // external trigger pin
    input wire logic extTrigPin,
    // analog multiplexer and sample stage
    input wire logic convDone,
    output logic sampleStart,
    output logic convAbort,
    output logic [3:0] muxChan,
    output logic muxSpecial,
    output logic muxReserved,
    output logic seqBusy
);
    // register state
    acs_byte_t startCtl_ff;
    acs_chan_t wrapChan_ff;
    logic [3:0] seqLen_ff;
    logic trigEnable_ff;
    logic seqDone_ff;
    logic trigOverrun_ff;
    logic [3:0] convCount_ff;
    logic trigArmed_ff;

    // sequencing state
    acs_state_e state_ff;
    acs_state_e nxt_state;
    acs_chan_t curChan_ff;
    acs_chan_t nxt_chan;
    acs_chan_t stepChan;
    logic [4:0] convLeft_ff;
    logic [4:0] nxt_convLeft;

    // output flops
    logic sampleStart_ff;
    logic convAbort_ff;
    logic [3:0] muxChan_ff;
    logic muxSpecial_ff;
    logic muxReserved_ff;
    logic seqBusy_ff;
    acs_byte_t rdData_ff;

    // trigger edge detect
    logic trigLevel;
    logic trigLevelDly_ff;
    logic trigEdge;

    // decoded events
    logic startWr;
    logic cfgWr;
    logic statusWr;
    logic trigStart;
    logic lastConv;
    logic convStep;
    logic seqEnd;
    logic rerun;
    logic specialMode;
    logic scanMode;
    logic multMode;
    acs_chan_t startCode;
    logic [4:0] lenCount;

    // field views of the start control register
    assign specialMode = startCtl_ff[`ACS_START_SPECIAL];
    assign scanMode = startCtl_ff[`ACS_START_SCAN];
    assign multMode = startCtl_ff[`ACS_START_ACROSS_CHANNELS_MODE];
    assign startCode = startCtl_ff[`ACS_START_CODE_HI:`ACS_START_CODE_LO];

    // zero length code means a full sixteen
    assign lenCount = (seqLen_ff == 4'h0) ? `ACS_LEN_FULL
                                          : {1'b0, seqLen_ff}; // RQ14

    // address decode
    always_comb begin
        startWr = 1'b0;
        cfgWr = 1'b0;
        statusWr = 1'b0;
        if (regWrEn && regAddr == `ACS_OFS_START) begin
            startWr = 1'b1; // RQ13
        end else if (regWrEn && regAddr == `ACS_OFS_WRAP) begin
            cfgWr = 1'b1;
        end else if (regWrEn && regAddr == `ACS_OFS_SEQCFG) begin
            cfgWr = 1'b1;
        end else if (regWrEn && regAddr == `ACS_OFS_STATUS) begin
            statusWr = 1'b1;
        end
    end

    // trigger pin
    acs_sync3 u_trigSync (
        .clk(clk),
        .reset(reset),
        .pinIn(extTrigPin),
        .levelOut(trigLevel)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            trigLevelDly_ff <= 1'b0;
        end else begin
            trigLevelDly_ff <= trigLevel;
        end
    end

    assign trigEdge = trigLevel & ~trigLevelDly_ff;

    // a trigger only starts a sequence once armed and while idle
    assign trigStart = trigEnable_ff && trigArmed_ff && trigEdge
                       && state_ff == ACS_IDLE && !startWr && !cfgWr; // RQ2

    // conversion bookkeeping
    assign convStep = (state_ff == ACS_WAIT) && convDone && !startWr
                      && !cfgWr;
    assign lastConv = (convLeft_ff == 5'h01);
    assign seqEnd = convStep && lastConv;
    // scan repeats only without trigger control
    assign rerun = seqEnd && scanMode && !trigEnable_ff; // RQ5 RQ6

    // multi-channel step
    acs_chan_step u_step ( // RQ9 RQ10
        .curChan(curChan_ff),
        .wrapChan(wrapChan_ff),
        .nextChan(stepChan)
    );

    // next state
    always_comb begin
        nxt_state = state_ff;
        if (startWr) begin
            // armed trigger mode waits, otherwise start at once
            nxt_state = trigEnable_ff ? ACS_IDLE : ACS_ISSUE; // RQ1 RQ2
        end else if (cfgWr) begin
            nxt_state = ACS_IDLE;
        end else begin
            case (state_ff)
                ACS_IDLE: begin
                    if (trigStart) begin
                        nxt_state = ACS_ISSUE;
                    end
                end
                ACS_ISSUE: begin
                    nxt_state = ACS_WAIT;
                end
                ACS_WAIT: begin
                    if (convStep && (!lastConv || rerun)) begin
                        nxt_state = ACS_ISSUE; // RQ5
                    end else if (seqEnd) begin
                        nxt_state = ACS_IDLE;
                    end
                end
                default: begin
                    nxt_state = ACS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= ACS_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // channel of the next conversion
    always_comb begin
        nxt_chan = curChan_ff;
        if (startWr) begin
            nxt_chan = regWrData[`ACS_START_CODE_HI:`ACS_START_CODE_LO];
        end else if (trigStart || rerun) begin
            nxt_chan = startCode;
        end else if (convStep && !lastConv && multMode) begin
            nxt_chan = stepChan; // RQ8
        end else if (convStep && !lastConv) begin
            nxt_chan = startCode; // RQ7
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            curChan_ff <= `ACS_RST_WRAP;
        end else begin
            curChan_ff <= nxt_chan;
        end
    end

    // conversions left in the running sequence
    always_comb begin
        nxt_convLeft = convLeft_ff;
        if (startWr || trigStart || rerun) begin
            nxt_convLeft = lenCount; // RQ8 RQ14
        end else if (convStep && !lastConv) begin
            nxt_convLeft = convLeft_ff - 5'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            convLeft_ff <= `ACS_LEN_FULL;
        end else begin
            convLeft_ff <= nxt_convLeft;
        end
    end

    // start control register, bit 7 kept at zero
    always_ff @(posedge clk) begin
        if (reset) begin
            startCtl_ff <= `ACS_RST_START;
        end else if (startWr) begin
            startCtl_ff <= regWrData & `ACS_START_WMASK; // RQ13 RQ16
        end
    end

    // configuration registers
    always_ff @(posedge clk) begin
        if (reset) begin
            wrapChan_ff <= `ACS_RST_WRAP;
            seqLen_ff <= `ACS_RST_LEN;
            trigEnable_ff <= 1'b0;
        end else if (cfgWr && regAddr == `ACS_OFS_WRAP) begin
            wrapChan_ff <= regWrData[3:0];
        end else if (cfgWr) begin
            seqLen_ff <= regWrData[`ACS_SEQCFG_LEN_HI:`ACS_SEQCFG_LEN_LO];
            trigEnable_ff <= regWrData[`ACS_SEQCFG_TRIGEN];
        end
    end

    // arming for trigger mode
    always_ff @(posedge clk) begin
        if (reset) begin
            trigArmed_ff <= 1'b0;
        end else if (startWr) begin
            trigArmed_ff <= 1'b1; // RQ2
        end else if (cfgWr) begin
            trigArmed_ff <= 1'b0;
        end
    end

    // sequence done flag, a setting event beats the clear
    always_ff @(posedge clk) begin
        if (reset) begin
            seqDone_ff <= 1'b0;
        end else if (seqEnd) begin
            seqDone_ff <= 1'b1;
        end else if (startWr) begin
            seqDone_ff <= 1'b0; // RQ15
        end else if (statusWr && regWrData[`ACS_STAT_DONE]) begin
            seqDone_ff <= 1'b0;
        end
    end

    // trigger arriving while a sequence runs
    always_ff @(posedge clk) begin
        if (reset) begin
            trigOverrun_ff <= 1'b0;
        end else if (trigEnable_ff && trigEdge && state_ff != ACS_IDLE) begin
            trigOverrun_ff <= 1'b1; // RQ6
        end else if (startWr || cfgWr) begin
            trigOverrun_ff <= 1'b0;
        end else if (statusWr && regWrData[`ACS_STAT_OVERRUN]) begin
            trigOverrun_ff <= 1'b0;
        end
    end

    // conversion counter, cleared at start, abort and sequence end
    always_ff @(posedge clk) begin
        if (reset) begin
            convCount_ff <= 4'h0;
        end else if (startWr || cfgWr || seqEnd) begin
            convCount_ff <= 4'h0; // RQ15
        end else if (convStep) begin
            convCount_ff <= convCount_ff + 4'h1;
        end
    end

    // sample start marks the sample phase of each channel
    always_ff @(posedge clk) begin
        if (reset) begin
            sampleStart_ff <= 1'b0;
        end else begin
            sampleStart_ff <= (nxt_state == ACS_ISSUE); // RQ3
        end
    end

    // abort of a running conversion
    always_ff @(posedge clk) begin
        if (reset) begin
            convAbort_ff <= 1'b0;
        end else begin
            convAbort_ff <= (startWr || cfgWr) && state_ff != ACS_IDLE; // RQ1
        end
    end

    // multiplexer selection
    always_ff @(posedge clk) begin
        if (reset) begin
            muxChan_ff <= 4'h0;
            muxSpecial_ff <= 1'b0;
            muxReserved_ff <= 1'b0;
        end else if (nxt_state == ACS_ISSUE) begin
            muxChan_ff <= nxt_chan; // RQ11
            muxSpecial_ff <= startWr ? regWrData[`ACS_START_SPECIAL]
                                     : specialMode; // RQ4
            if (startWr ? regWrData[`ACS_START_SPECIAL] : specialMode) begin
                muxReserved_ff <= nxt_chan != `ACS_CODE_REFHI
                                  && nxt_chan != `ACS_CODE_REFLO
                                  && nxt_chan != `ACS_CODE_REFMID; // RQ12
            end else begin
                muxReserved_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            seqBusy_ff <= 1'b0;
        end else begin
            seqBusy_ff <= (nxt_state != ACS_IDLE);
        end
    end

    // read data one cycle after the strobe, unmapped reads zero
    always_ff @(posedge clk) begin
        if (reset) begin
            rdData_ff <= 8'h00;
        end else if (!regRdEn) begin
            rdData_ff <= 8'h00;
        end else if (regAddr == `ACS_OFS_START) begin
            rdData_ff <= startCtl_ff; // RQ13 RQ16
        end else if (regAddr == `ACS_OFS_WRAP) begin
            rdData_ff <= {4'h0, wrapChan_ff};
        end else if (regAddr == `ACS_OFS_SEQCFG) begin
            rdData_ff <= {trigEnable_ff, 3'h0, seqLen_ff};
        end else if (regAddr == `ACS_OFS_STATUS) begin
            rdData_ff <= {seqDone_ff, 1'b0, trigOverrun_ff, 1'b0,
                          convCount_ff};
        end else begin
            rdData_ff <= 8'h00;
        end
    end

    assign regRdData = rdData_ff;
    assign sampleStart = sampleStart_ff;
    assign convAbort = convAbort_ff;
    assign muxChan = muxChan_ff;
    assign muxSpecial = muxSpecial_ff;
    assign muxReserved = muxReserved_ff;
    assign seqBusy = seqBusy_ff;
endmodule

// ==== src/acs_sync3.sv ====
// Purpose: three-stage synchroniser for a pin level
// Assumes: one clock, synchronous reset
// Notes: level counts once stages two and three agree
`timescale 1ns/1ps
module acs_sync3 (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // raw pin and settled level
    input wire logic pinIn,
    output logic levelOut
);
    logic stageA_ff;
    logic stageB_ff;
    logic stageC_ff;
    logic level_ff;

    always_ff @(posedge clk) begin
        if (reset) begin
            stageA_ff <= 1'b0;
            stageB_ff <= 1'b0;
            stageC_ff <= 1'b0;
        end else begin
            stageA_ff <= pinIn;
            stageB_ff <= stageA_ff;
            stageC_ff <= stageB_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            level_ff <= 1'b0;
        end else if (stageB_ff == stageC_ff) begin
            level_ff <= stageC_ff;
        end
    end

    assign levelOut = level_ff;
endmodule

// ==== testbench/acs_sample_model.sv ====
// Purpose: behavioural sample stage beside the controller
// Assumes: one conversion in flight at a time
// Notes: delay sets how slowly each conversion ends
`timescale 1ns/1ps
module acs_sample_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // speed setting
    input wire logic [7:0] delay,
    // controller link
    input wire logic sampleStart,
    input wire logic convAbort,
    output logic convDone
);
    logic busy_ff;
    logic [7:0] cnt_ff;
    always_ff @(posedge clk) begin
        convDone <= 1'b0;
        if (reset) begin
            busy_ff <= 1'b0;
            cnt_ff <= 8'h00;
        end else if (sampleStart) begin
            busy_ff <= 1'b1;
            cnt_ff <= delay;
        end else if (convAbort) begin
            busy_ff <= 1'b0;
        end else if (busy_ff && cnt_ff == 8'h00) begin
            busy_ff <= 1'b0;
            convDone <= 1'b1;
        end else if (busy_ff) begin
            cnt_ff <= cnt_ff - 8'h01;
        end
    end
endmodule

// ==== testbench/acs_seq_ctrl_assertions.sv ====
// Purpose: port assertions for the sequence controller
// Assumes: register shadows rebuilt from port traffic
// Notes: bound to acs_seq_ctrl below
`timescale 1ns/1ps
`include "acs_map.svh"
module acs_seq_ctrl_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    // trigger and sample stage
    input wire logic extTrigPin,
    input wire logic convDone,
    input wire logic sampleStart,
    input wire logic convAbort,
    input wire logic [3:0] muxChan,
    input wire logic muxSpecial,
    input wire logic muxReserved,
    input wire logic seqBusy
);
    logic [6:0] ctl_ff;
    logic [3:0] wrap_ff;
    logic [3:0] last_ff;
    logic trig_ff;
    logic startWr;
    logic [3:0] stepChan;
    assign startWr = regWrEn && regAddr == `ACS_OFS_START;
    assign stepChan = last_ff == wrap_ff ? 4'h0 : last_ff + 4'h1;
    // shadows of start control, wrap point and trigger enable
    always_ff @(posedge clk) begin
        if (reset) begin
            ctl_ff <= 7'h00;
            wrap_ff <= 4'h0;
            trig_ff <= 1'b0;
        end else if (regWrEn) begin
            if (regAddr == `ACS_OFS_START) ctl_ff <= regWrData[6:0];
            if (regAddr == `ACS_OFS_WRAP) wrap_ff <= regWrData[3:0];
            if (regAddr == `ACS_OFS_SEQCFG) trig_ff <= regWrData[7];
        end
    end
    always_ff @(posedge clk) begin
        if (reset) last_ff <= 4'h0;
        else if (sampleStart) last_ff <= muxChan;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    AST_START_NEXT: assert property (
        startWr && !trig_ff |=> sampleStart && muxChan == ctl_ff[3:0])
        else $error("start write did not start the coded channel");
    AST_START_ABORT: assert property (
        startWr && seqBusy && !trig_ff |=> convAbort)
        else $error("start write did not abort the running sequence");
    AST_READ_START: assert property (
        regRdEn && regAddr == `ACS_OFS_START |=> regRdData == {1'b0, ctl_ff})
        else $error("start control read back wrong");
    AST_READ_QUIET: assert property (
        !regRdEn |=> regRdData == 8'h00)
        else $error("read data outside the answer cycle");
    AST_ONE_CHAN: assert property (
        sampleStart && !ctl_ff[4] |-> muxChan == ctl_ff[3:0])
        else $error("single channel mode moved the channel");
    AST_STEP_CHAN: assert property (
        sampleStart && ctl_ff[4]
        |-> muxChan == stepChan || muxChan == ctl_ff[3:0])
        else $error("multi channel step wrong");
    AST_SPECIAL: assert property (
        sampleStart |-> muxSpecial == ctl_ff[6] && muxReserved == (ctl_ff[6]
        && !(muxChan inside {`ACS_CODE_REFHI, `ACS_CODE_REFLO,
        `ACS_CODE_REFMID})))
        else $error("special channel flags wrong");
    AST_ONE_SHOT: assert property (
        sampleStart && !regWrEn |=> !sampleStart)
        else $error("sample start longer than one cycle");
    AST_IDLE: assert property (
        !seqBusy && !trig_ff && !regWrEn |=> !sampleStart)
        else $error("sample start while idle");
    cover property (startWr && seqBusy);
    cover property (sampleStart && ctl_ff[4] && muxChan == 4'h0);
    cover property (sampleStart && muxSpecial);
endmodule
bind acs_seq_ctrl acs_seq_ctrl_assertions chk (
    .clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .extTrigPin(extTrigPin), .convDone(convDone),
    .sampleStart(sampleStart), .convAbort(convAbort), .muxChan(muxChan),
    .muxSpecial(muxSpecial), .muxReserved(muxReserved), .seqBusy(seqBusy)
);

// ==== testbench/testbench.sv ====
// Purpose: self-checking bench for the sequence controller
// Assumes: sample stage model answers every start
// Notes: table rows first, then abort, scan, trigger, reset
`timescale 1ns/1ps
`include "acs_map.svh"
module testbench;
    typedef struct {
        logic [7:0] ctl;
        logic [3:0] wrap;
        logic [3:0] len;
        logic [7:0] dly;
        logic [7:0] back;
    } acs_row_s;
    logic clk, reset, regWrEn, regRdEn, extTrigPin, convDone;
    logic sampleStart, convAbort, muxSpecial, muxReserved, seqBusy;
    logic [3:0] regAddr, muxChan;
    logic [7:0] regWrData, regRdData, dly, rdv;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    int m;
    acs_row_s rows [6] = '{
        '{8'h03, 4'h0, 4'h3, 8'h00, 8'h03},
        '{8'h1C, 4'hD, 4'h4, 8'h05, 8'h1C},
        '{8'h1E, 4'h3, 4'h4, 8'h01, 8'h1E},
        '{8'h10, 4'hF, 4'h0, 8'h00, 8'h10},
        '{8'h54, 4'h0, 4'h3, 8'h02, 8'h54},
        '{8'hD2, 4'h9, 4'h2, 8'h00, 8'h52}};
    acs_seq_ctrl dut (
        .clk(clk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .extTrigPin(extTrigPin),
        .convDone(convDone), .sampleStart(sampleStart),
        .convAbort(convAbort), .muxChan(muxChan), .muxSpecial(muxSpecial),
        .muxReserved(muxReserved), .seqBusy(seqBusy));
    acs_sample_model stage (
        .clk(clk), .reset(reset), .delay(dly), .sampleStart(sampleStart),
        .convAbort(convAbort), .convDone(convDone));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chkv(input string s, input logic [7:0] e, g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        @(posedge clk);
        d = regRdData;
    endtask
    // follows one sequence, stepping the expected channel
    task automatic seq(input acs_row_s r, input logic ab);
        logic [3:0] ch;
        logic [7:0] n, got;
        logic rs;
        ch = r.ctl[3:0];
        n = r.len == 4'h0 ? 8'h10 : {4'h0, r.len};
        got = 8'h00;
        for (int t = 0; t < 600; t++) begin
            if (sampleStart === 1'b1) begin
                rs = r.ctl[6] && !(ch inside {4'h4, 4'h5, 4'h6});
                if (got == 8'h00)
                    chkv("convAbort", {7'h0, ab}, {7'h0, convAbort});
                chkv("muxChan", {4'h0, ch}, {4'h0, muxChan});
                chkv("muxFlags", {6'h0, r.ctl[6], rs},
                    {6'h0, muxSpecial, muxReserved});
                got++;
                if (r.ctl[4])
                    ch = ch == r.wrap ? 4'h0 : ch + 4'h1;
            end
            if (seqBusy !== 1'b1 && got != 8'h00)
                break;
            @(posedge clk);
        end
        chkv("convCount", n, got);
        chkv("seqBusy", 8'h00, {7'h0, seqBusy});
    endtask
    initial begin
        reset = 1'b1;
        regAddr = 4'h0;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        extTrigPin = 1'b0;
        dly = 8'h00;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        foreach (rows[i]) begin
            dly <= rows[i].dly;
            wr(`ACS_OFS_WRAP, {4'h0, rows[i].wrap});
            wr(`ACS_OFS_SEQCFG, {4'h0, rows[i].len});
            wr(`ACS_OFS_START, rows[i].ctl);
            seq(rows[i], 1'b0);
            rd(`ACS_OFS_START, rdv);
            chkv("startReg", rows[i].back, rdv);
            rd(`ACS_OFS_STATUS, rdv);
            chkv("status", 8'h80, rdv);
        end
        // restart while a slow conversion is in flight
        dly <= 8'h14;
        wr(`ACS_OFS_SEQCFG, 8'h01);
        wr(`ACS_OFS_START, 8'h01);
        rd(`ACS_OFS_STATUS, rdv);
        chkv("statusRun", 8'h00, rdv);
        wr(`ACS_OFS_START, 8'h17);
        seq('{8'h17, 4'h0, 4'h1, 8'h14, 8'h17}, 1'b1);
        rd(`ACS_OFS_STATUS, rdv);
        chkv("statusNew", 8'h80, rdv);
        // continuous mode keeps sampling
        dly <= 8'h00;
        wr(`ACS_OFS_SEQCFG, 8'h02);
        wr(`ACS_OFS_START, 8'h25);
        m = 0;
        repeat (60) begin
            @(posedge clk);
            if (sampleStart === 1'b1)
                m++;
        end
        chkv("scanRuns", 8'h01, {7'h0, m > 8});
        // armed by one write, then one sequence per trigger
        wr(`ACS_OFS_SEQCFG, 8'h82);
        wr(`ACS_OFS_START, 8'h21);
        m = 0;
        repeat (12) begin
            @(posedge clk);
            if (sampleStart === 1'b1)
                m++;
        end
        chkv("armedQuiet", 8'h00, m[7:0]);
        for (int k = 0; k < 2; k++) begin
            extTrigPin <= 1'b1;
            seq('{8'h21, 4'h0, 4'h2, 8'h00, 8'h21}, 1'b0);
            extTrigPin <= 1'b0;
            repeat (6) @(posedge clk);
        end
        // trigger while busy sets overrun, status write clears
        dly <= 8'h30;
        extTrigPin <= 1'b1;
        repeat (10) @(posedge clk);
        extTrigPin <= 1'b0;
        repeat (6) @(posedge clk);
        extTrigPin <= 1'b1;
        repeat (6) @(posedge clk);
        rd(`ACS_OFS_STATUS, rdv);
        chkv("overrun", 8'hA0, rdv);
        wr(`ACS_OFS_STATUS, 8'hA0);
        rd(`ACS_OFS_STATUS, rdv);
        chkv("statusClr", 8'h00, rdv);
        extTrigPin <= 1'b0;
        // second reset, then unmapped read
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(`ACS_OFS_START, rdv);
        chkv("startRst", 8'h00, rdv);
        rd(4'h9, rdv);
        chkv("unmapped", 8'h00, rdv);
        conclude();
    end
endmodule
